// ### core/flsg_bus_cycle.sv
// One asynchronous flash bus cycle: read, program-data write or command write.
// Assumes flash pins are resolved by the bench from the enable signals.
`timescale 1ns/1ps
`default_nettype none
module flsg_bus_cycle (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request from sequencer
  input wire logic start,
  input wire logic wr,
  input wire logic cmd,
  input wire logic word_mode,
  input wire logic [20:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic done,
  // Flash pins
  output logic [19:0] fl_addr,
  input wire logic [15:0] fl_dq_in,
  output logic [15:0] fl_dq_out,
  output logic [15:0] fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  flsg_pkg::flsg_bc_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic wr_ff, cmd_ff, word_ff;
  logic [15:0] dq_s1_ff, dq_s2_ff, rdata_ff;
  logic [15:0] drive_mask;
  logic cnt_end;
  // ------------------------------------------------------------
  // Phase sequencing
  // ------------------------------------------------------------
  assign cnt_end = (cnt_ff == 4'h1);
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff - 4'h1;
    unique case (st_ff)
      flsg_pkg::BC_IDLE: begin
        nxt_cnt = wr ? flsg_pkg::WP_CYC : flsg_pkg::RD_CYC;
        if (start) nxt_st = flsg_pkg::BC_ACT;
      end
      flsg_pkg::BC_ACT: if (cnt_end) begin
        nxt_st = flsg_pkg::BC_REC;
        nxt_cnt = wr_ff ? flsg_pkg::WPH_CYC : flsg_pkg::OEPH_CYC;
      end
      flsg_pkg::BC_REC: if (cnt_end) nxt_st = flsg_pkg::BC_IDLE;
      default: nxt_st = flsg_pkg::BC_IDLE;
    endcase
  end
  // Command bytes only on the low lane; byte mode frees 14:8, 15 carries addr lsb
  assign drive_mask = {~word_ff | (wr_ff & ~cmd_ff), {7{word_ff & wr_ff & ~cmd_ff}},
                       {8{wr_ff}}};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= flsg_pkg::BC_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      cmd_ff <= 1'b0;
      word_ff <= 1'b1;
      fl_addr <= 20'h00000;
      fl_dq_out <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      if (st_ff == flsg_pkg::BC_IDLE && start) begin
        wr_ff <= wr;
        cmd_ff <= cmd;
        word_ff <= word_mode;
        fl_addr <= addr[20:1];
        fl_dq_out <= {word_mode ? (cmd ? 1'b0 : wdata[15]) : addr[0],
                      (cmd ? 7'h00 : wdata[14:8]), wdata[7:0]};
      end
    end
  end
  // ------------------------------------------------------------
  // Pin strobes: write needs ce and we low with oe high
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_dq_oe_n <= 16'hFFFF;
    end else begin
      fl_ce_n <= (nxt_st != flsg_pkg::BC_ACT);
      fl_oe_n <= !(nxt_st == flsg_pkg::BC_ACT && !nxt_wr());
      fl_we_n <= !(nxt_st == flsg_pkg::BC_ACT && nxt_wr());
      fl_dq_oe_n <= (nxt_st == flsg_pkg::BC_ACT) ? ~nxt_mask() : 16'hFFFF;
    end
  end
  function automatic logic nxt_wr();
    return (st_ff == flsg_pkg::BC_IDLE) ? wr : wr_ff;
  endfunction
  function automatic logic [15:0] nxt_mask();
    logic w;
    logic c;
    logic m;
    w = nxt_wr();
    c = (st_ff == flsg_pkg::BC_IDLE) ? cmd : cmd_ff;
    m = (st_ff == flsg_pkg::BC_IDLE) ? word_mode : word_ff;
    return {~m | (w & ~c), {7{m & w & ~c}}, {8{w}}};
  endfunction
  // ------------------------------------------------------------
  // Read capture through a two-stage synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_s1_ff <= 16'h0000;
      dq_s2_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
    end else begin
      dq_s1_ff <= fl_dq_in;
      dq_s2_ff <= dq_s1_ff;
      if (st_ff == flsg_pkg::BC_ACT && cnt_end && !wr_ff)
        rdata_ff <= word_ff ? dq_s2_ff : {8'h00, dq_s2_ff[7:0]};
    end
  end
  assign rdata = rdata_ff;
  assign done = (st_ff == flsg_pkg::BC_REC) && cnt_end;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_write_strobe;
    @(posedge aclk) disable iff (!aresetn) !fl_we_n |-> (!fl_ce_n && fl_oe_n);
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("we low without ce low/oe high");
  property p_cmd_byte;
    @(posedge aclk) disable iff (!aresetn)
      (!fl_we_n && cmd_ff) |-> (&fl_dq_oe_n[14:8]) && !(|fl_dq_oe_n[7:0]);
  endproperty
  a_cmd_byte: assert property (p_cmd_byte) else $error("command write not byte wide");
  property p_done_quiet;
    @(posedge aclk) disable iff (!aresetn) done |-> fl_we_n && fl_ce_n ##1 fl_we_n;
  endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("strobe active at cycle end");
  property p_lane_mask;
    @(posedge aclk) disable iff (!aresetn) !fl_ce_n |-> fl_dq_oe_n == ~drive_mask;
  endproperty
  a_lane_mask: assert property (p_lane_mask) else $error("data lanes differ from width mask");
endmodule
`default_nettype wire

// ### core/flsg_host.sv
// Host controller: AXI4-Lite registers, flash bus cycles and toggle-bit polling.
// Assumes one parallel NOR flash whose ready/busy line has an external pull-up.
`timescale 1ns/1ps
`default_nettype none
module flsg_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash pins
  output logic [19:0] fl_addr,
  input wire logic [15:0] fl_dq_in,
  output logic [15:0] fl_dq_out,
  output logic [15:0] fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_word_mode,
  output logic fl_reset_n,
  input wire logic ready_busy_in
);
  logic aw_got_ff, w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [31:0] ctrl_ff, addr_ff, wreg_ff;
  logic [15:0] rdata_ff;
  logic done_ff, pass_ff, fail_ff, tmo_ff, first_ff;
  logic rb_s1_ff, rb_s2_ff;
  logic wr_fire, start_req, eng_done, eng_start_ff, toggling, equal_ok;
  logic wr_hit, rd_hit;
  logic [31:0] rd_mux, status_w;
  logic [15:0] eng_rdata;
  flsg_pkg::flsg_seq_t st_ff, nxt_st;
  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    return a == flsg_pkg::OFS_CTRL || a == flsg_pkg::OFS_ADDR || a == flsg_pkg::OFS_WDATA
        || a == flsg_pkg::OFS_RDATA || a == flsg_pkg::OFS_STATUS;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    return {s[3] ? n[31:24] : o[31:24], s[2] ? n[23:16] : o[23:16],
            s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_ff && w_got_ff;
  assign wr_hit = mapped(awaddr_ff);
  assign rd_hit = mapped(s_axi_araddr);
  assign start_req = wr_fire && awaddr_ff == flsg_pkg::OFS_CTRL && wstrb_ff[0]
                     && wdata_ff[flsg_pkg::CTRL_START] && st_ff == flsg_pkg::SQ_IDLE;
  assign status_w = {26'h0, tmo_ff, rb_s2_ff, fail_ff, pass_ff, done_ff,
                     st_ff != flsg_pkg::SQ_IDLE};
  assign rd_mux = (s_axi_araddr == flsg_pkg::OFS_CTRL) ? ctrl_ff :
                  (s_axi_araddr == flsg_pkg::OFS_ADDR) ? addr_ff :
                  (s_axi_araddr == flsg_pkg::OFS_WDATA) ? wreg_ff :
                  (s_axi_araddr == flsg_pkg::OFS_RDATA) ? {16'h0000, rdata_ff} : status_w;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= flsg_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= flsg_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? flsg_pkg::RESP_OKAY : flsg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_mux : 32'h0000_0000;
        s_axi_rresp <= rd_hit ? flsg_pkg::RESP_OKAY : flsg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // Control registers; settings frozen while a job runs
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= flsg_pkg::CTRL_RST;
      addr_ff <= 32'h0000_0000;
      wreg_ff <= 32'h0000_0000;
      rb_s1_ff <= 1'b1;
      rb_s2_ff <= 1'b1;
    end else begin
      rb_s1_ff <= ready_busy_in;
      rb_s2_ff <= rb_s1_ff;
      if (wr_fire && st_ff == flsg_pkg::SQ_IDLE) begin
        if (awaddr_ff == flsg_pkg::OFS_CTRL)
          ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_003E;
        if (awaddr_ff == flsg_pkg::OFS_ADDR) addr_ff <= merge(addr_ff, wdata_ff, wstrb_ff);
        if (awaddr_ff == flsg_pkg::OFS_WDATA) wreg_ff <= merge(wreg_ff, wdata_ff, wstrb_ff);
      end
    end
  end
  assign fl_word_mode = ctrl_ff[flsg_pkg::CTRL_WORD];
  assign fl_reset_n = !ctrl_ff[flsg_pkg::CTRL_HOLD_RST];
  // ------------------------------------------------------------
  // Toggle-bit polling sequencer
  // ------------------------------------------------------------
  assign toggling = eng_rdata[flsg_pkg::BIT_TOGGLE_ONE] != first_ff;
  assign equal_ok = eng_done && !toggling;
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      flsg_pkg::SQ_IDLE: if (start_req) begin
        nxt_st = (wdata_ff[2:1] == flsg_pkg::OP_POLL) ? flsg_pkg::SQ_RD1 : flsg_pkg::SQ_XFER;
      end
      flsg_pkg::SQ_XFER: if (eng_done) nxt_st = flsg_pkg::SQ_IDLE;
      flsg_pkg::SQ_RD1: if (eng_done) nxt_st = flsg_pkg::SQ_RD2;
      flsg_pkg::SQ_RD2: if (eng_done) begin
        if (!toggling) nxt_st = flsg_pkg::SQ_IDLE;
        else if (eng_rdata[flsg_pkg::BIT_TIMEOUT]) nxt_st = flsg_pkg::SQ_RD3;
        else nxt_st = flsg_pkg::SQ_RD1;
      end
      flsg_pkg::SQ_RD3: if (eng_done) nxt_st = flsg_pkg::SQ_RD4;
      flsg_pkg::SQ_RD4: if (eng_done) begin
        nxt_st = toggling ? flsg_pkg::SQ_RST : flsg_pkg::SQ_IDLE;
      end
      flsg_pkg::SQ_RST: if (eng_done) nxt_st = flsg_pkg::SQ_IDLE;
      default: nxt_st = flsg_pkg::SQ_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= flsg_pkg::SQ_IDLE;
      eng_start_ff <= 1'b0;
      first_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      done_ff <= 1'b0;
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
      tmo_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      eng_start_ff <= (nxt_st != flsg_pkg::SQ_IDLE) && (nxt_st != st_ff || eng_done);
      if (eng_done) rdata_ff <= eng_rdata;
      if (eng_done && (st_ff == flsg_pkg::SQ_RD1 || st_ff == flsg_pkg::SQ_RD3))
        first_ff <= eng_rdata[flsg_pkg::BIT_TOGGLE_ONE];
      if (start_req) begin
        done_ff <= 1'b0;
        pass_ff <= 1'b0;
        fail_ff <= 1'b0;
        tmo_ff <= 1'b0;
      end
      if (eng_done && st_ff == flsg_pkg::SQ_RD2 && toggling)
        tmo_ff <= eng_rdata[flsg_pkg::BIT_TIMEOUT];
      if ((st_ff == flsg_pkg::SQ_RD2 || st_ff == flsg_pkg::SQ_RD4) && equal_ok)
        pass_ff <= 1'b1;
      if (st_ff == flsg_pkg::SQ_RD4 && eng_done && toggling) fail_ff <= 1'b1;
      if (nxt_st == flsg_pkg::SQ_IDLE && st_ff != flsg_pkg::SQ_IDLE) done_ff <= 1'b1;
    end
  end
  flsg_bus_cycle u_cyc (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(eng_start_ff),
    .wr(st_ff == flsg_pkg::SQ_RST || (st_ff == flsg_pkg::SQ_XFER && ctrl_ff[2:1] == flsg_pkg::OP_WRITE)),
    .cmd(st_ff == flsg_pkg::SQ_RST || ctrl_ff[flsg_pkg::CTRL_CMD]),
    .word_mode(ctrl_ff[flsg_pkg::CTRL_WORD]),
    .addr(addr_ff[20:0]),
    .wdata(st_ff == flsg_pkg::SQ_RST ? flsg_pkg::RESET_CMD : wreg_ff[15:0]),
    .rdata(eng_rdata),
    .done(eng_done),
    .fl_addr(fl_addr),
    .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_rd2_toggle;
    st_ff == flsg_pkg::SQ_RD2 && eng_done && toggling;
  endsequence
  property p_double_read;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff == flsg_pkg::SQ_RD1 && eng_done) |=> st_ff == flsg_pkg::SQ_RD2 && eng_start_ff;
  endproperty
  a_double_read: assert property (p_double_read) else $error("poll skipped second read");
  property p_steady_done;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff == flsg_pkg::SQ_RD2 && equal_ok) |=> st_ff == flsg_pkg::SQ_IDLE && pass_ff && done_ff;
  endproperty
  a_steady_done: assert property (p_steady_done) else $error("steady flag not reported done");
  property p_recheck;
    @(posedge aclk) disable iff (!aresetn)
      (s_rd2_toggle and eng_rdata[flsg_pkg::BIT_TIMEOUT]) |=> st_ff == flsg_pkg::SQ_RD3 && tmo_ff;
  endproperty
  a_recheck: assert property (p_recheck) else $error("no recheck after timeout flag");
  property p_fail_reset;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff == flsg_pkg::SQ_RD4 && eng_done && toggling) |=> st_ff == flsg_pkg::SQ_RST
        && fail_ff ##[1:40] !fl_we_n && fl_dq_out[7:0] == flsg_pkg::RESET_CMD[7:0];
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("failure without reset command");
  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
      (s_rd2_toggle and !eng_rdata[flsg_pkg::BIT_TIMEOUT]) |=> st_ff == flsg_pkg::SQ_RD1;
  endproperty
  a_restart: assert property (p_restart) else $error("poll did not restart double read");
endmodule
`default_nettype wire

// ### core/flsg_pkg.sv
// Constants for the flash status and write guard host controller.
// Assumes a 40 MHz aclk and a parallel NOR flash on the far side.
package flsg_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_CMD = 3;
  localparam int CTRL_WORD = 4;
  localparam int CTRL_HOLD_RST = 5;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_PASS = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_READY_PIN = 4;
  localparam int ST_TIMEOUT = 5;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_TOGGLE_ONE = 6;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_POLL = 2'h2;
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int T_RC_NS = 90;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 30;
  localparam int T_OEPH_NS = 20;
  localparam int SYNC_CYC = 2;
  localparam logic [3:0] RD_CYC = 4'((T_RC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WPH_CYC = 4'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] OEPH_CYC = 4'((T_OEPH_NS + CLK_NS - 1) / CLK_NS);
  // ------------------------------------------------------------
  // Sequencer states, Gray on the poll steps from SQ_RD1 through SQ_RST
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SQ_IDLE = 3'h0,
    SQ_XFER = 3'h1,
    SQ_RD1 = 3'h3,
    SQ_RD2 = 3'h2,
    SQ_RD3 = 3'h6,
    SQ_RD4 = 3'h7,
    SQ_RST = 3'h5
  } flsg_seq_t;
  typedef enum logic [1:0] {
    BC_IDLE = 2'h0,
    BC_ACT = 2'h1,
    BC_REC = 2'h3
  } flsg_bc_t;
endpackage

// ### tb/flsg_flash_model.sv
// Behavioural parallel NOR flash: toggle status, ready/busy, write guard.
// Assumes the bench resolves the data bus and the ready/busy pull-up.
`timescale 1ns/1ps
`default_nettype none
module flsg_flash_model (
  // Control pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic stuck,
  // Address and data
  input wire logic [19:0] addr,
  input wire logic [15:0] dq,
  output logic [15:0] q,
  output logic rb_pull
);
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic [19:0] wa = 20'h00000;
  logic busy = 1'b0;
  logic armed = 1'b0;
  logic tog = 1'b0;
  logic tmo = 1'b0;
  int nwr = 0;
  int nrd = 0;
  wire logic rd_act = !ce_n && !oe_n;
  wire logic wr_act = !ce_n && !we_n && oe_n;
  initial begin
    q = 16'h0000;
    for (int i = 0; i < 16; i++) mem[i] = 16'hA5C0 + 16'(i);
  end
  // Released bus shows the inverse, so a stale value never passes
  always @(rd_act, busy, tog, tmo, addr)
    if (rd_act && reset_n)
      q = busy ? {8'h00, ~last[7], tog, tmo, 5'h04} : mem[addr[3:0]];
    else
      q = ~q;
  // End of a read cycle
  always @(negedge rd_act)
    if (busy) begin
      tog = ~tog;
      nrd++;
      tmo = stuck && nrd >= 2;
      if (!stuck && nrd >= 5) busy = 0;
    end
  // Sample well inside the strobe; edges race with the data release
  always @(posedge wr_act) begin
    #1;
    wd = dq;
    wa = addr;
    armed = 1'b1;
  end
  // A strobe already low at power-up has no opening edge and is not a write
  always @(negedge wr_act)
    if (reset_n && armed) begin
      armed = 1'b0;
      if (wd[7:0] == 8'hF0) begin
        busy = 0;
        tmo = 0;
        nwr = 0;
      end else if (!busy) begin
        nwr++;
        if (nwr == 4) begin
          mem[wa[3:0]] = wd;
          last = wd;
          busy = 1;
          nrd = 0;
          nwr = 0;
        end
      end
    end
  assign rb_pull = busy || !reset_n;
endmodule
`default_nettype wire

// ### tb/tb_flash_status_and_write_guard.sv
// Self-checking bench for the flash host controller over AXI4-Lite.
// Assumes flsg_flash_model on the pins and a pull-up on ready/busy.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_and_write_guard;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, stuck = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rv;
  logic [1:0] rr;
  logic [2:0] byte_seen = 3'h0;
  logic [6:0] hi_oe = 7'h0;
  wire logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, wmode, rst_n, rb_pull;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [19:0] fa;
  wire logic [15:0] dq_o, dq_oe_n, q, dq;
  int n_mismatch = 0, n_tests = 0;
  always #12.5 aclk = ~aclk;
  assign dq = (dq_o & ~dq_oe_n) | (q & dq_oe_n);
  always @(posedge aclk) begin
    if (!oe_n && !wmode) byte_seen <= {dq_oe_n[15], dq_o[15], &dq_oe_n[14:8]};
    if (!we_n) hi_oe <= dq_oe_n[14:8];
  end
  flsg_host dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fl_addr(fa), .fl_dq_in(dq), .fl_dq_out(dq_o), .fl_dq_oe_n(dq_oe_n), .fl_ce_n(ce_n),
    .fl_oe_n(oe_n), .fl_we_n(we_n), .fl_word_mode(wmode), .fl_reset_n(rst_n),
    .ready_busy_in(!rb_pull));
  flsg_flash_model flash_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n),
    .stuck(stuck), .addr(fa), .dq(dq), .q(q), .rb_pull(rb_pull));
  // ------------------------------------------------------------
  // Checks and closing
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    n_mismatch++;
    $display("MISMATCH %s expected answer seen timeout", nm);
    stop_test();
  endtask
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1) break;
    end
    if (i == 100) hang("write answer");
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1) break;
    end
    if (i == 100) hang("read answer");
    rv = rdata;
    rr = rresp;
  endtask
  task automatic job(input logic [1:0] op, input logic c, input logic w,
                     input logic [20:0] a, input logic [15:0] d);
    int i;
    wr(flsg_pkg::OFS_ADDR, {11'h0, a}, flsg_pkg::RESP_OKAY);
    wr(flsg_pkg::OFS_WDATA, {16'h0, d}, flsg_pkg::RESP_OKAY);
    wr(flsg_pkg::OFS_CTRL, {26'h0, 1'b0, w, c, op, 1'b1}, flsg_pkg::RESP_OKAY);
    for (i = 0; i < 300; i++) begin
      rd(flsg_pkg::OFS_STATUS);
      if (rv[flsg_pkg::ST_DONE] === 1'b1) break;
    end
    if (i == 300) hang("job done");
  endtask
  // Three command bytes, then the data word
  task automatic prog(input logic [20:0] a, input logic [15:0] d);
    job(flsg_pkg::OP_WRITE, 1, 1, 21'hAAA, 16'h00AA);
    chk("cmd upper lines", 32'h7F, {25'h0, hi_oe});
    job(flsg_pkg::OP_WRITE, 1, 1, 21'h554, 16'h0055);
    job(flsg_pkg::OP_WRITE, 1, 1, 21'hAAA, 16'h00A0);
    job(flsg_pkg::OP_WRITE, 0, 1, a, d);
    chk("data upper lines", 32'h0, {25'h0, hi_oe});
    rd(flsg_pkg::OFS_STATUS);
    chk("ready pin busy", 32'h0, {31'h0, rv[flsg_pkg::ST_READY_PIN]});
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(flsg_pkg::OFS_CTRL);
    chk("ctrl reset", flsg_pkg::CTRL_RST, rv);
    rd(8'h40);
    chk("unmapped rresp", {30'h0, flsg_pkg::RESP_SLVERR}, {30'h0, rr});
    chk("unmapped rdata", 32'h0, rv);
    wr(8'h40, 32'h5A, flsg_pkg::RESP_SLVERR);
    wr(flsg_pkg::OFS_CTRL, 32'h0000_0030, flsg_pkg::RESP_OKAY);
    rd(flsg_pkg::OFS_STATUS);
    rd(flsg_pkg::OFS_STATUS);
    chk("ready pin in reset", 32'h0, {31'h0, rv[flsg_pkg::ST_READY_PIN]});
    wr(flsg_pkg::OFS_CTRL, flsg_pkg::CTRL_RST, flsg_pkg::RESP_OKAY);
    rd(flsg_pkg::OFS_STATUS);
    rd(flsg_pkg::OFS_STATUS);
    chk("ready pin standby", 32'h1, {31'h0, rv[flsg_pkg::ST_READY_PIN]});
    $display("Test registers done");
    job(flsg_pkg::OP_READ, 0, 1, 21'h6, 16'h0);
    rd(flsg_pkg::OFS_RDATA);
    chk("word read", 32'h0000_A5C3, rv);
    job(flsg_pkg::OP_READ, 0, 0, 21'h7, 16'h0);
    chk("byte lsb pin", 32'h3, {29'h0, byte_seen});
    $display("Test reads done");
    prog(21'hA, 16'h1234);
    job(flsg_pkg::OP_POLL, 0, 1, 21'hA, 16'h0);
    chk("poll pass", 32'h1, {31'h0, rv[flsg_pkg::ST_PASS]});
    chk("poll no fail", 32'h0, {31'h0, rv[flsg_pkg::ST_FAIL]});
    chk("ready pin after", 32'h1, {31'h0, rv[flsg_pkg::ST_READY_PIN]});
    job(flsg_pkg::OP_READ, 0, 1, 21'hA, 16'h0);
    rd(flsg_pkg::OFS_RDATA);
    chk("programmed word", 32'h0000_1234, rv);
    $display("Test program poll done");
    stuck <= 1;
    prog(21'hC, 16'h3C3C);
    job(flsg_pkg::OP_POLL, 0, 1, 21'hC, 16'h0);
    chk("poll fail", 32'h1, {31'h0, rv[flsg_pkg::ST_FAIL]});
    chk("timeout seen", 32'h1, {31'h0, rv[flsg_pkg::ST_TIMEOUT]});
    stuck <= 0;
    rd(flsg_pkg::OFS_STATUS);
    chk("ready after reset cmd", 32'h1, {31'h0, rv[flsg_pkg::ST_READY_PIN]});
    $display("Test timeout poll done");
    stop_test();
  end
endmodule
`default_nettype wire
